/* verif/bsis_checker.sv */
// concurrent checks on the boundary-scan block's outputs
// assumes binding into bsis_top; all checks run on clk_in
`timescale 1ns/10ps
`include "bsis_defs.svh"
module bsis_checker
  import bsis_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       tdo_oe_out,
  input wire logic       bsr_shift_out,
  input wire logic       bsr_drive_out,
  input wire logic       ac_mode_out,
  input wire logic       ac_pulse_out,
  input wire logic [5:0] instr_out,
  input bsis_tap_e       tap_state_out
);
  // one clock and one reset for every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // output driver only switches on inside a shift state
  oe_in_shift_a: assert property ($rose(tdo_oe_out) |->
    tap_state_out inside {BSIS_SHIFT_DR, BSIS_SHIFT_IR})
    else $error("tdo enabled outside a shift state");
  // settled reset state selects identification and stays quiet
  tlr_idcode_a: assert property ((tap_state_out == BSIS_TLR) [*2] |->
    instr_out == `BSIS_OP_IDCODE && !tdo_oe_out)
    else $error("reset state without identification instruction");
  // instruction changes only at update or in reset
  instr_hold_a: assert property ($changed(instr_out) |->
    $past(tap_state_out) inside {BSIS_UPD_IR, BSIS_TLR}
    || tap_state_out == BSIS_TLR)
    else $error("instruction changed outside update");
  // ac mode follows the two ac opcodes
  ac_mode_a: assert property ($rose(ac_mode_out) |->
    instr_out inside {`BSIS_OP_EXT_TRAIN, `BSIS_OP_EXT_PULSE})
    else $error("ac mode without ac instruction");
  // no pulse away from run-test/idle
  pulse_idle_a: assert property ((tap_state_out != BSIS_RTI) [*2] |->
    !ac_pulse_out)
    else $error("ac pulse outside run-test idle");
  // pulse level covers the idle stay from its second clock on
  pulse_width_a: assert property ((tap_state_out == BSIS_RTI
    && instr_out == `BSIS_OP_EXT_PULSE) [*2] |-> ac_pulse_out)
    else $error("pulse low while idle under pulse mode");
  // clamp keeps the cells driving
  clamp_drive_a: assert property ((instr_out == `BSIS_OP_CLAMP) [*2]
    |-> bsr_drive_out)
    else $error("clamp without cell drive");
  // bypass and clamp never shift the boundary chain
  byp_no_chain_a: assert property (instr_out inside
    {`BSIS_OP_BYPASS, `BSIS_OP_CLAMP} |-> !bsr_shift_out)
    else $error("chain shifted while bypassed");
endmodule

bind bsis_top bsis_checker bsis_checker_i (
  .clk_in        (clk_in),
  .sys_rst_in    (sys_rst_in),
  .tdo_oe_out    (tdo_oe_out),
  .bsr_shift_out (bsr_shift_out),
  .bsr_drive_out (bsr_drive_out),
  .ac_mode_out   (ac_mode_out),
  .ac_pulse_out  (ac_pulse_out),
  .instr_out     (instr_out),
  .tap_state_out (tap_state_out)
);

/* verif/bsis_tester.sv */
// board tester model driving the test port with an 800 ns clock
// assumes the bench calls step and set_trst hierarchically
`timescale 1ns/10ps
module bsis_tester (
  input  wire logic tdo_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  output logic      trst_n_out,
  output logic      obs_bit_out,
  output logic      obs_stb_out
);
  // test reset held low, mode select high at start
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_n_out = 1'b0;
    obs_bit_out = 1'b0;
    obs_stb_out = 1'b0;
  end

  // test reset level
  task automatic set_trst(input logic v);
    trst_n_out = v;
  endtask

  // one test clock period; tdo is taken just before the rise
  task automatic step(input logic m, input logic d, input logic c);
    tms_out = m;
    tdi_out = d;
    #400;
    obs_bit_out = tdo_in;
    obs_stb_out = c;
    tck_out = 1'b1;
    #400;
    obs_stb_out = 1'b0;
    tck_out = 1'b0;
    // mode and data lines keep their level until the next step sets them
  endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench for the boundary-scan block
// assumes bsis_top, the tester model and the checker are compiled first
`timescale 1ns/10ps
`include "bsis_defs.svh"
module tb_top;
  import bsis_pkg::*;
  localparam logic [10:0] MK = 11'h155; // arbitrary value
  localparam logic [15:0] PT = 16'h0F0F; // arbitrary value
  localparam logic [3:0]  RV = 4'h3;     // arbitrary value
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [3:0]  chain_r = 4'h0;
  logic        tck, tms, tdi, trst_n, obs_bit, obs_stb, tdo;
  logic        si, cap, shf, drive, ac_mode, ac_pulse, p;
  logic        upd, hiz;
  int          n_upd = 0;
  logic [5:0]  instr;
  bsis_tap_e   tap;
  logic [31:0] d;
  logic        exp_q[$];
  int          bad_count = 0;
  int          n_checks = 0;
  int unsigned seed_v;

  always #50 clk_in = ~clk_in;

  bsis_tester bsis_tester_i (.tdo_in(tdo), .tck_out(tck), .tms_out(tms),
    .tdi_out(tdi), .trst_n_out(trst_n), .obs_bit_out(obs_bit),
    .obs_stb_out(obs_stb));

  bsis_top #(.MAKER_CODE(MK), .PART_CODE(PT), .REVISION(RV)) bsis_top_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(),
    .bsr_so_in(chain_r[0]), .bsr_si_out(si), .bsr_capture_out(cap),
    .bsr_shift_out(shf), .bsr_update_out(upd), .bsr_drive_out(drive),
    .bsr_highz_out(hiz), .ac_mode_out(ac_mode), .ac_pulse_out(ac_pulse),
    .instr_out(instr), .tap_state_out(tap));

  // four-cell boundary chain; capture loads a fixed pattern, updates counted
  always @(posedge clk_in) begin
    if (cap) chain_r <= 4'hA;
    else if (shf) chain_r <= {si, chain_r[3:1]};
    if (upd) n_upd++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // wait in system clocks, then return off the clock edge
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
    #37;
  endtask

  // shift n bits lsb first, noting each expected tdo bit
  task automatic scan(input int n, input logic [31:0] v,
                      input logic [31:0] e);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      bsis_tester_i.step(i == n - 1, v[i], 1'b1);
    end
  endtask

  // from idle to shift-dr
  task automatic to_dr();
    bsis_tester_i.step(1'b1, 1'b1, 1'b0);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
  endtask

  // from exit1 through update back to idle
  task automatic to_idle();
    bsis_tester_i.step(1'b1, 1'b1, 1'b0);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
  endtask

  // load an instruction; the capture pattern comes out first
  task automatic ld_ir(input logic [5:0] op);
    bsis_tester_i.step(1'b1, 1'b1, 1'b0);
    to_dr();
    scan(6, {26'h0, op}, 32'h2D);
    to_idle();
    waitc(4);
    check(instr, op);
  endtask

  // compare each observed tdo bit with the oldest note
  always @(posedge obs_stb) begin
    if (exp_q.size() == 0) begin
      bad_count++;
      $display("[FAIL] %0t unexpected tdo bit", $time);
    end else check(obs_bit, exp_q.pop_front());
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial begin
    seed_v = $urandom(32'hA5BE);
    waitc(8);
    sys_rst_in = 1'b0;
    bsis_tester_i.set_trst(1'b1);
    waitc(4);
    check(instr, `BSIS_OP_IDCODE);
    check(tap, BSIS_TLR);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    to_dr();
    scan(32, $urandom, {RV, PT, MK, 1'b1});
    to_idle();
    // bypass and clamp: captured zero, then a one-bit delay
    for (int k = 0; k < 2; k++) begin
      ld_ir(k ? `BSIS_OP_CLAMP : `BSIS_OP_BYPASS);
      check(drive, k[0]);
      check(hiz, 1'b0);
      to_dr();
      d = $urandom;
      scan(8, d, {d[6:0], 1'b0});
      to_idle();
    end
    repeat (5) bsis_tester_i.step(1'b1, 1'b1, 1'b0);
    waitc(4);
    check(instr, `BSIS_OP_IDCODE);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    ld_ir(`BSIS_OP_EXT_PULSE);
    check(ac_mode, 1'b1);
    check(ac_pulse, 1'b1);
    bsis_tester_i.step(1'b1, 1'b1, 1'b0);
    waitc(3);
    check(ac_pulse, 1'b0);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    d = $urandom;
    scan(8, d, {d[3:0], 4'hA});
    to_idle();
    ld_ir(`BSIS_OP_EXT_TRAIN);
    p = ac_pulse;
    bsis_tester_i.step(1'b0, 1'b1, 1'b0);
    waitc(2);
    check(ac_pulse, !p);
    bsis_tester_i.set_trst(1'b0);
    waitc(5);
    check(instr, `BSIS_OP_IDCODE);
    check(n_upd, 1);
    check(exp_q.size(), 0);
    stop_test();
  end
endmodule

/* verilog/bsis_defs.svh */
// constants of the boundary-scan instruction block
// assumes inclusion by the package and the design files by bare name
`ifndef BSIS_DEFS_SVH
`define BSIS_DEFS_SVH

// instruction register width and opcodes
`define BSIS_IR_W          6
`define BSIS_OP_EXTEST     6'h00
`define BSIS_OP_SAMPLE     6'h01
`define BSIS_OP_IDCODE     6'h02
`define BSIS_OP_HIGHZ      6'h03
`define BSIS_OP_VALIDATE   6'h2D
`define BSIS_OP_EXT_TRAIN  6'h3C
`define BSIS_OP_EXT_PULSE  6'h3D
`define BSIS_OP_CLAMP      6'h3E
`define BSIS_OP_BYPASS     6'h3F

// identification value layout
`define BSIS_ID_W          32
`define BSIS_ID_LSB_POS    0
`define BSIS_ID_MAKER_LO   1
`define BSIS_ID_MAKER_W    11
`define BSIS_ID_PART_LO    12
`define BSIS_ID_PART_W     16
`define BSIS_ID_REV_LO     28
`define BSIS_ID_REV_W      4
`define BSIS_ID_LSB_VAL    1'h1

// default identity fields, arbitrary values
`define BSIS_MAKER_DEF     11'h2A5
`define BSIS_PART_DEF      16'h1234
`define BSIS_REV_DEF       4'h0

// bypass capture value
`define BSIS_BYP_CAPTURE   1'h0

`endif

/* verilog/bsis_pkg.sv */
// types of the boundary-scan instruction block
// assumes bsis_defs.svh is on the include path
package bsis_pkg;
  `include "bsis_defs.svh"

  // test state machine states
  typedef enum logic [3:0] {
    BSIS_TLR, BSIS_RTI, BSIS_SEL_DR, BSIS_CAP_DR, BSIS_SHIFT_DR,
    BSIS_EXIT1_DR, BSIS_PAUSE_DR, BSIS_EXIT2_DR, BSIS_UPD_DR,
    BSIS_SEL_IR, BSIS_CAP_IR, BSIS_SHIFT_IR, BSIS_EXIT1_IR,
    BSIS_PAUSE_IR, BSIS_EXIT2_IR, BSIS_UPD_IR
  } bsis_tap_e;

  // data register on the serial path
  typedef enum logic [1:0] {
    BSIS_DR_BYPASS, BSIS_DR_ID, BSIS_DR_BSR
  } bsis_dr_e;
endpackage

/* verilog/bsis_tap_fsm.sv */
// test state machine, stepped on each detected test clock rise
// assumes synchronised mode select and a one-cycle rise strobe
`timescale 1ns/10ps
module bsis_tap_fsm (
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                trst_n_in,
  input  wire logic                tck_rise_in,
  input  wire logic                tms_in,
  output bsis_pkg::bsis_tap_e      state_out
);
  import bsis_pkg::*;

  bsis_tap_e state_r;
  bsis_tap_e state_nxt;

  // one step of the standard sixteen-state graph
  function automatic bsis_tap_e step(input bsis_tap_e s, input logic m);
    bsis_tap_e n;
    n = s;
    unique case (s)
      BSIS_TLR:      n = m ? BSIS_TLR      : BSIS_RTI;
      BSIS_RTI:      n = m ? BSIS_SEL_DR   : BSIS_RTI;
      BSIS_SEL_DR:   n = m ? BSIS_SEL_IR   : BSIS_CAP_DR;
      BSIS_CAP_DR:   n = m ? BSIS_EXIT1_DR : BSIS_SHIFT_DR;
      BSIS_SHIFT_DR: n = m ? BSIS_EXIT1_DR : BSIS_SHIFT_DR;
      BSIS_EXIT1_DR: n = m ? BSIS_UPD_DR   : BSIS_PAUSE_DR;
      BSIS_PAUSE_DR: n = m ? BSIS_EXIT2_DR : BSIS_PAUSE_DR;
      BSIS_EXIT2_DR: n = m ? BSIS_UPD_DR   : BSIS_SHIFT_DR;
      BSIS_UPD_DR:   n = m ? BSIS_SEL_DR   : BSIS_RTI;
      BSIS_SEL_IR:   n = m ? BSIS_TLR      : BSIS_CAP_IR;
      BSIS_CAP_IR:   n = m ? BSIS_EXIT1_IR : BSIS_SHIFT_IR;
      BSIS_SHIFT_IR: n = m ? BSIS_EXIT1_IR : BSIS_SHIFT_IR;
      BSIS_EXIT1_IR: n = m ? BSIS_UPD_IR   : BSIS_PAUSE_IR;
      BSIS_PAUSE_IR: n = m ? BSIS_EXIT2_IR : BSIS_PAUSE_IR;
      BSIS_EXIT2_IR: n = m ? BSIS_UPD_IR   : BSIS_SHIFT_IR;
      BSIS_UPD_IR:   n = m ? BSIS_SEL_DR   : BSIS_RTI;
    endcase
    return n;
  endfunction

  // test reset forces the reset state, five high mode bits reach it too
  always_comb begin
    state_nxt = state_r;
    if (!trst_n_in) begin
      state_nxt = BSIS_TLR; // RULE4
    end else if (tck_rise_in) begin
      state_nxt = step(state_r, tms_in);
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= BSIS_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_out = state_r;
endmodule

/* verilog/bsis_top.sv */
// boundary-scan instruction, bypass and identification logic
// assumes the test pins come from another domain and are sampled here;
// the boundary cell chain sits outside, on this clock, behind bsr_* ports
//
// Operation
// RULE1 - bypass bit loads zero in Capture-DR
// RULE2 - bypass gives one-bit path TDI to TDO
// RULE3 - clamp holds outputs, routes through bypass
// RULE4 - test reset makes IDCODE current
// RULE5 - identification value lsb is always one
// RULE6 - bypass exists; identification selected after reset
// RULE7 - IDCODE shifts 32 bits, lsb first
// RULE8 - id fields: one, maker, part, revision
// RULE9 - Capture-IR loads VALIDATE pattern ending 01
// RULE10 - AC instructions take effect at falling clock
// RULE11 - AC instructions shift through boundary path
// RULE12 - train pulses last while in Run-Test/Idle
// RULE13 - pulse width equals Run-Test/Idle time
// RULE14 - no Run-Test/Idle behaves as plain EXTEST
// RULE15 - tester never loads reserved instruction codes
// RULE16 - system keeps state machine in reset
// RULE17 - idle test clock driven low by tester
// RULE18 - six-bit instruction latched at Update-IR
// RULE19 - opcode decode; other codes are reserved
`timescale 1ns/10ps
`include "bsis_defs.svh"
module bsis_top #(
  parameter logic [10:0] MAKER_CODE = `BSIS_MAKER_DEF, // arbitrary value
  parameter logic [15:0] PART_CODE  = `BSIS_PART_DEF,  // arbitrary value
  parameter logic [3:0]  REVISION   = `BSIS_REV_DEF    // arbitrary value
) (
  input  wire logic            clk_in,
  input  wire logic            sys_rst_in,
  input  wire logic            tck_in,
  input  wire logic            tms_in,
  input  wire logic            tdi_in,
  input  wire logic            trst_n_in,
  output logic                 tdo_out,
  output logic                 tdo_oe_out,
  input  wire logic            bsr_so_in,
  output logic                 bsr_si_out,
  output logic                 bsr_capture_out,
  output logic                 bsr_shift_out,
  output logic                 bsr_update_out,
  output logic                 bsr_drive_out,
  output logic                 bsr_highz_out,
  output logic                 ac_mode_out,
  output logic                 ac_pulse_out,
  output logic [5:0]           instr_out,
  output bsis_pkg::bsis_tap_e  tap_state_out
);
  import bsis_pkg::*;

  localparam int IRW = `BSIS_IR_W;
  localparam int IDW = `BSIS_ID_W;

  // identification value built from its fields
  localparam logic [31:0] ID_VALUE = {REVISION, PART_CODE, MAKER_CODE,
                                      `BSIS_ID_LSB_VAL}; // RULE5 RULE8

  // selects the data register that an instruction puts on the path
  function automatic bsis_dr_e dr_select(input logic [5:0] op);
    bsis_dr_e d;
    d = BSIS_DR_BYPASS;
    unique case (op)
      `BSIS_OP_IDCODE:    d = BSIS_DR_ID;
      `BSIS_OP_EXTEST,
      `BSIS_OP_SAMPLE,
      `BSIS_OP_EXT_TRAIN,
      `BSIS_OP_EXT_PULSE: d = BSIS_DR_BSR; // RULE11
      default:            d = BSIS_DR_BYPASS; // RULE3 RULE19
    endcase
    return d;
  endfunction

  // true for instructions that let the boundary cells drive the pins
  function automatic logic drives_pins(input logic [5:0] op);
    return (op == `BSIS_OP_EXTEST) || (op == `BSIS_OP_CLAMP) ||
           (op == `BSIS_OP_EXT_TRAIN) || (op == `BSIS_OP_EXT_PULSE);
  endfunction

  // ---- pin synchronisers
  logic tck_s1_r, tck_s2_r, tck_s3_r;
  logic tms_s1_r, tms_s2_r;
  logic tdi_s1_r, tdi_s2_r;
  logic trst_s1_r, trst_s2_r;
  logic tck_rise;
  logic tck_fall;

  // two flops per pin, a third on the clock for edge finding
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tck_s1_r  <= 1'h0;
      tck_s2_r  <= 1'h0;
      tck_s3_r  <= 1'h0;
      tms_s1_r  <= 1'h1;
      tms_s2_r  <= 1'h1;
      tdi_s1_r  <= 1'h1;
      tdi_s2_r  <= 1'h1;
      trst_s1_r <= 1'h0;
      trst_s2_r <= 1'h0;
    end else begin
      tck_s1_r  <= tck_in;
      tck_s2_r  <= tck_s1_r;
      tck_s3_r  <= tck_s2_r;
      tms_s1_r  <= tms_in;
      tms_s2_r  <= tms_s1_r;
      tdi_s1_r  <= tdi_in;
      tdi_s2_r  <= tdi_s1_r;
      trst_s1_r <= trst_n_in;
      trst_s2_r <= trst_s1_r;
    end
  end

  // test clock edges seen by the system clock
  assign tck_rise = tck_s2_r & ~tck_s3_r;
  assign tck_fall = ~tck_s2_r & tck_s3_r;

  // ---- test state machine
  bsis_tap_e state;

  bsis_tap_fsm u_fsm (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .trst_n_in   (trst_s2_r),
    .tck_rise_in (tck_rise),
    .tms_in      (tms_s2_r),
    .state_out   (state)
  );

  // ---- instruction register
  logic [IRW-1:0] ir_shift_r, ir_shift_nxt;
  logic [IRW-1:0] ir_r, ir_nxt;

  // capture, shift and latch of the instruction
  always_comb begin
    ir_shift_nxt = ir_shift_r;
    ir_nxt       = ir_r;
    if (tck_rise && state == BSIS_CAP_IR) begin
      ir_shift_nxt = `BSIS_OP_VALIDATE; // RULE9
    end else if (tck_rise && state == BSIS_SHIFT_IR) begin
      ir_shift_nxt = {tdi_s2_r, ir_shift_r[IRW-1:1]};
    end
    if (!trst_s2_r || state == BSIS_TLR) begin
      ir_nxt = `BSIS_OP_IDCODE; // RULE4 RULE6
    end else if (tck_fall && state == BSIS_UPD_IR) begin
      ir_nxt = ir_shift_r; // RULE10 RULE18
    end
  end

  // instruction registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ir_shift_r <= `BSIS_OP_IDCODE;
      ir_r       <= `BSIS_OP_IDCODE;
    end else begin
      ir_shift_r <= ir_shift_nxt;
      ir_r       <= ir_nxt;
    end
  end

  // ---- data registers
  bsis_dr_e       sel;
  logic           bypass_r, bypass_nxt;
  logic [IDW-1:0] id_r, id_nxt;
  logic           cap_dr;
  logic           sh_dr;

  assign sel    = dr_select(ir_r);
  assign cap_dr = tck_rise && (state == BSIS_CAP_DR);
  assign sh_dr  = tck_rise && (state == BSIS_SHIFT_DR);

  // bypass bit and identification shifter
  always_comb begin
    bypass_nxt = bypass_r;
    id_nxt     = id_r;
    if (cap_dr) begin
      bypass_nxt = `BSIS_BYP_CAPTURE; // RULE1
      id_nxt     = ID_VALUE; // RULE7
    end else if (sh_dr) begin
      bypass_nxt = tdi_s2_r; // RULE2
      id_nxt     = {tdi_s2_r, id_r[IDW-1:1]}; // RULE7
    end
  end

  // data registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bypass_r <= 1'h0;
      id_r     <= '0;
    end else begin
      bypass_r <= bypass_nxt;
      id_r     <= id_nxt;
    end
  end

  // ---- serial output, changed on the falling test clock
  logic tdo_r, tdo_nxt;
  logic tdo_oe_r, tdo_oe_nxt;

  // pick the bit at the head of the active path
  always_comb begin
    tdo_nxt    = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    if (!trst_s2_r) begin
      tdo_oe_nxt = 1'h0;
    end else if (tck_fall) begin
      tdo_oe_nxt = (state == BSIS_SHIFT_IR) || (state == BSIS_SHIFT_DR);
      if (state == BSIS_SHIFT_IR) begin
        tdo_nxt = ir_shift_r[0];
      end else if (state == BSIS_SHIFT_DR) begin
        unique case (sel)
          BSIS_DR_ID:     tdo_nxt = id_r[0]; // RULE5 RULE7
          BSIS_DR_BSR:    tdo_nxt = bsr_so_in; // RULE11
          BSIS_DR_BYPASS: tdo_nxt = bypass_r; // RULE2 RULE3
        endcase
      end
    end
  end

  // serial output registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tdo_r    <= 1'h0;
      tdo_oe_r <= 1'h0;
    end else begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // ---- boundary chain control
  logic bsr_si_r, bsr_si_nxt;
  logic bsr_cap_r, bsr_cap_nxt;
  logic bsr_sh_r, bsr_sh_nxt;
  logic bsr_upd_r, bsr_upd_nxt;
  logic drive_r, drive_nxt;
  logic highz_r, highz_nxt;

  // strobes to the external cells and the pin control levels
  always_comb begin
    bsr_si_nxt  = tdi_s2_r;
    bsr_cap_nxt = cap_dr && (sel == BSIS_DR_BSR);
    bsr_sh_nxt  = sh_dr && (sel == BSIS_DR_BSR); // RULE11
    bsr_upd_nxt = tck_fall && (state == BSIS_UPD_DR) &&
                  (sel == BSIS_DR_BSR);
    drive_nxt   = drives_pins(ir_r); // RULE3 RULE14
    highz_nxt   = (ir_r == `BSIS_OP_HIGHZ);
  end

  // boundary control registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bsr_si_r  <= 1'h0;
      bsr_cap_r <= 1'h0;
      bsr_sh_r  <= 1'h0;
      bsr_upd_r <= 1'h0;
      drive_r   <= 1'h0;
      highz_r   <= 1'h0;
    end else begin
      bsr_si_r  <= bsr_si_nxt;
      bsr_cap_r <= bsr_cap_nxt;
      bsr_sh_r  <= bsr_sh_nxt;
      bsr_upd_r <= bsr_upd_nxt;
      drive_r   <= drive_nxt;
      highz_r   <= highz_nxt;
    end
  end

  // ---- AC pin pulse generation
  logic ac_mode_r, ac_mode_nxt;
  logic ac_pulse_r, ac_pulse_nxt;
  logic is_train;
  logic is_pulse;

  assign is_train = (ir_r == `BSIS_OP_EXT_TRAIN);
  assign is_pulse = (ir_r == `BSIS_OP_EXT_PULSE);

  // train toggles per test clock rise in idle; pulse is high in idle
  always_comb begin
    ac_mode_nxt  = is_train || is_pulse; // RULE10
    ac_pulse_nxt = 1'h0; // RULE14
    if (state == BSIS_RTI) begin
      if (is_train) begin
        ac_pulse_nxt = tck_rise ? ~ac_pulse_r : ac_pulse_r; // RULE12
      end else if (is_pulse) begin
        ac_pulse_nxt = 1'h1; // RULE13
      end
    end
  end

  // AC registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ac_mode_r  <= 1'h0;
      ac_pulse_r <= 1'h0;
    end else begin
      ac_mode_r  <= ac_mode_nxt;
      ac_pulse_r <= ac_pulse_nxt;
    end
  end

  // ---- outputs
  assign tdo_out         = tdo_r;
  assign tdo_oe_out      = tdo_oe_r;
  assign bsr_si_out      = bsr_si_r;
  assign bsr_capture_out = bsr_cap_r;
  assign bsr_shift_out   = bsr_sh_r;
  assign bsr_update_out  = bsr_upd_r;
  assign bsr_drive_out   = drive_r;
  assign bsr_highz_out   = highz_r;
  assign ac_mode_out     = ac_mode_r;
  assign ac_pulse_out    = ac_pulse_r;
  assign instr_out       = ir_r;
  assign tap_state_out   = state;
endmodule
